// file: hdl/vsd_pkg.sv
// Constants and types shared by the bus slave address decoder
package vsd_pkg;
  // ==========================================================================
  // Address modifier codes
  localparam logic [5:0] AM_A24_SUP_BLT  = 6'h3F;
  localparam logic [5:0] AM_A24_SUP_DATA = 6'h3D;
  localparam logic [5:0] AM_A24_SUP_MBLT = 6'h3C;
  localparam logic [5:0] AM_A24_USR_BLT  = 6'h3B;
  localparam logic [5:0] AM_A24_USR_DATA = 6'h39;
  localparam logic [5:0] AM_A24_USR_MBLT = 6'h38;
  localparam logic [5:0] AM_CR_CSR       = 6'h2F;
  localparam logic [5:0] AM_A32_SUP_BLT  = 6'h0F;
  localparam logic [5:0] AM_A32_SUP_DATA = 6'h0D;
  localparam logic [5:0] AM_A32_SUP_MBLT = 6'h0C;
  localparam logic [5:0] AM_A32_USR_BLT  = 6'h0B;
  localparam logic [5:0] AM_A32_USR_DATA = 6'h09;
  localparam logic [5:0] AM_A32_USR_MBLT = 6'h08;
  // ==========================================================================
  // Register offsets (relative to the base address)
  localparam logic [15:0] OFS_BUF_LIMIT = 16'h0800;
  localparam logic [15:0] OFS_BITSET1   = 16'h1030;
  localparam logic [15:0] OFS_BITCLR1   = 16'h1032;
  localparam logic [15:0] OFS_BASE_HI   = 16'h1034;
  localparam logic [15:0] OFS_BASE_LO   = 16'h1036;
  localparam logic [15:0] OFS_CTRL      = 16'h1038;
  localparam logic [15:0] OFS_STATUS    = 16'h103A;
  // ==========================================================================
  // Field positions and reset values
  localparam int          BIT_BASE_SRC    = 4;
  localparam int          BIT_SLIDE       = 0;
  localparam int          BIT_ZS_FINE     = 1;
  localparam int          POS_IRQ_LVL     = 2;
  localparam logic [15:0] RST_BITSET1     = 16'h0000;
  localparam logic [15:0] RST_BASE_HI     = 16'h0000;
  localparam logic [15:0] RST_BASE_LO     = 16'h0000;
  localparam logic [15:0] RST_CTRL        = 16'h0000;
  localparam logic [15:0] RST_BASE_ADDR   = 16'h0000;
  localparam logic [2:0]  RST_IRQ_LVL     = 3'h0;
  // ==========================================================================
  // Conversion figures
  localparam logic [11:0] FSR_FULL        = 12'h0FFF;
  localparam logic [11:0] FSR_SLIDE       = 12'h0F00;
  localparam logic [4:0]  ZS_STEP_COARSE  = 5'h10;
  localparam logic [4:0]  ZS_STEP_FINE    = 5'h02;
  localparam int          ZS_FINE_SHIFT   = 3;
  localparam logic [2:0]  IRQ_LEVEL_MAX   = 3'h7;
  // ==========================================================================
  // Data width codes on the dwidth input
  localparam logic [1:0]  DW_D16          = 2'h1;
  localparam logic [1:0]  DW_D32          = 2'h2;
  localparam logic [1:0]  DW_D64          = 2'h3;
  // ==========================================================================
  // Types
  typedef enum logic [3:0] {
    SP_NONE = 4'b0001,
    SP_A24  = 4'b0010,
    SP_A32  = 4'b0100,
    SP_CSR  = 4'b1000
  } vsd_space_e;
  typedef enum logic [2:0] {
    XF_SINGLE = 3'b001,
    XF_BLT    = 3'b010,
    XF_MBLT   = 3'b100
  } vsd_xfer_e;
endpackage : vsd_pkg

// file: hdl/vsd_addr_decode.sv
// Bus slave address decoder: modifier check, base compare, register file
// Behaviour
// - Accept A24 supervisory modifiers 3F, 3D, 3C
// - Accept A24 user modifiers 3B, 39, 38
// - Accept A32 supervisory modifiers 0F, 0D, 0C
// - Accept A32 user modifiers 0B, 09, 08
// - Accept CR/CSR space with modifier 2F
// - Decode 24-bit or 32-bit address words
// - Base on 64k boundary; low bits are offset
// - Bit set 1 register bit 4 low selects switch base
// - Bit set 1 register bit 4 high selects register base
// - Upper register gives A31..24, lower A23..16
// - Interrupter level programmable over seven levels
// - Buffer read single D32, BLT, MBLT
// - Registers take D16 and D32 cycles
// - Threshold step 16 full, 2 over eighth
// - Sliding scale limits range to 3840
module vsd_addr_decode (
  input  wire logic                clk,              // Bus clock
  input  wire logic                rst,              // Synchronous reset, active high
  input  wire logic                ce,               // Clock enable, freezes all state
  input  wire logic                req,              // Address phase strobe, one cycle
  input  wire logic [5:0]          am,               // Address modifier
  input  wire logic [31:0]         addr,             // Address word
  input  wire logic                wr,               // Write when high
  input  wire logic [1:0]          dwidth,           // Data width code
  input  wire logic [15:0]         wdata,            // Write data
  input  wire logic [15:0]         rot_sw,           // Rotary switches, A31..A16
  input  wire logic [4:0]          geo_slot,         // Slot number for CR/CSR space
  output vsd_pkg::vsd_space_e      space,            // Space of the last selected cycle
  output vsd_pkg::vsd_xfer_e       xfer,             // Transfer type of the last cycle
  output logic                     board_sel,        // Cycle addresses this board
  output logic                     bus_ack,          // Register or CSR cycle done
  output logic                     bus_err,          // Selected but illegal cycle
  output logic                     buf_rd,           // Buffer read handed downstream
  output logic [15:0]              reg_offset,       // Offset within the board
  output logic [15:0]              rdata,            // Register read data
  output logic                     base_from_regs,   // Base taken from registers
  output logic [15:0]              base_addr,        // Active base, A31..A16
  output logic [11:0]              full_scale_range, // Usable conversion range
  output logic [4:0]               zs_step,          // Threshold step in counts
  output logic [11:0]              zs_span,          // Top of threshold range
  output logic [2:0]               irq_level         // Interrupter level, 0 off
);

  // ==========================================================================
  // Storage
  logic [15:0]         bitset1;
  logic [15:0]         base_hi;
  logic [15:0]         base_lo;
  logic [15:0]         ctrl;

  // ==========================================================================
  // Modifier classification
  vsd_pkg::vsd_space_e next_space;
  vsd_pkg::vsd_xfer_e  next_xfer;

  always_comb begin
    next_space = vsd_pkg::SP_NONE;
    next_xfer  = vsd_pkg::XF_SINGLE;
    case (am)
      vsd_pkg::AM_A24_SUP_BLT,
      vsd_pkg::AM_A24_USR_BLT: begin
        next_space = vsd_pkg::SP_A24;
        next_xfer  = vsd_pkg::XF_BLT;
      end
      vsd_pkg::AM_A24_SUP_DATA,
      vsd_pkg::AM_A24_USR_DATA: begin
        next_space = vsd_pkg::SP_A24;
      end
      vsd_pkg::AM_A24_SUP_MBLT,
      vsd_pkg::AM_A24_USR_MBLT: begin
        next_space = vsd_pkg::SP_A24;
        next_xfer  = vsd_pkg::XF_MBLT;
      end
      vsd_pkg::AM_A32_SUP_BLT,
      vsd_pkg::AM_A32_USR_BLT: begin
        next_space = vsd_pkg::SP_A32;
        next_xfer  = vsd_pkg::XF_BLT;
      end
      vsd_pkg::AM_A32_SUP_DATA,
      vsd_pkg::AM_A32_USR_DATA: begin
        next_space = vsd_pkg::SP_A32;
      end
      vsd_pkg::AM_A32_SUP_MBLT,
      vsd_pkg::AM_A32_USR_MBLT: begin
        next_space = vsd_pkg::SP_A32;
        next_xfer  = vsd_pkg::XF_MBLT;
      end
      vsd_pkg::AM_CR_CSR: begin
        next_space = vsd_pkg::SP_CSR;
      end
      default: begin
        next_space = vsd_pkg::SP_NONE;
      end
    endcase
  end

  // ==========================================================================
  // Base address selection and compare
  logic [15:0]         active_base;
  logic                next_hit;
  logic [15:0]         ofs;

  // Switches or the two base registers, chosen by bit set 1 register bit 4
  assign active_base = bitset1[vsd_pkg::BIT_BASE_SRC]
                     ? {base_hi[7:0], base_lo[7:0]}
                     : rot_sw;
  assign ofs         = addr[15:0];

  always_comb begin
    next_hit = 1'b0;
    if (next_space == vsd_pkg::SP_A24) begin
      next_hit = (addr[23:16] == active_base[7:0]);
    end else if (next_space == vsd_pkg::SP_A32) begin
      next_hit = (addr[31:16] == active_base);
    end else if (next_space == vsd_pkg::SP_CSR) begin
      next_hit = (addr[23:19] == geo_slot);
    end
  end

  // ==========================================================================
  // Cycle legality
  logic                is_buf;
  logic                is_reg;
  logic                reg_width_ok;
  logic                buf_ok;
  logic                reg_ok;
  logic                csr_ok;

  assign is_buf       = (ofs < vsd_pkg::OFS_BUF_LIMIT);
  assign is_reg       = (ofs == vsd_pkg::OFS_BITSET1) || (ofs == vsd_pkg::OFS_BITCLR1)
                     || (ofs == vsd_pkg::OFS_BASE_HI) || (ofs == vsd_pkg::OFS_BASE_LO)
                     || (ofs == vsd_pkg::OFS_CTRL)    || (ofs == vsd_pkg::OFS_STATUS);
  assign reg_width_ok = (next_xfer == vsd_pkg::XF_SINGLE)
                     && ((dwidth == vsd_pkg::DW_D16) || (dwidth == vsd_pkg::DW_D32));
  assign buf_ok       = !wr && (((next_xfer != vsd_pkg::XF_MBLT) && (dwidth == vsd_pkg::DW_D32))
                     || ((next_xfer == vsd_pkg::XF_MBLT) && (dwidth == vsd_pkg::DW_D64)));
  assign reg_ok       = (next_space != vsd_pkg::SP_CSR) && is_reg && reg_width_ok;
  assign csr_ok       = (next_space == vsd_pkg::SP_CSR) && reg_width_ok;

  logic                reg_wr;
  assign reg_wr = ce && req && next_hit && reg_ok && wr;

  // ==========================================================================
  // Register file
  logic [15:0]         next_bitset1;

  always_comb begin
    next_bitset1 = bitset1;
    if (reg_wr && (ofs == vsd_pkg::OFS_BITSET1)) begin
      next_bitset1 = bitset1 | wdata;
    end else if (reg_wr && (ofs == vsd_pkg::OFS_BITCLR1)) begin
      next_bitset1 = bitset1 & ~wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bitset1        <= vsd_pkg::RST_BITSET1;
      base_from_regs <= vsd_pkg::RST_BITSET1[vsd_pkg::BIT_BASE_SRC];
    end else if (ce) begin
      bitset1        <= next_bitset1;
      base_from_regs <= next_bitset1[vsd_pkg::BIT_BASE_SRC];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      base_hi <= vsd_pkg::RST_BASE_HI;
      base_lo <= vsd_pkg::RST_BASE_LO;
      ctrl    <= vsd_pkg::RST_CTRL;
    end else if (reg_wr) begin
      if (ofs == vsd_pkg::OFS_BASE_HI) begin
        base_hi <= wdata;
      end else if (ofs == vsd_pkg::OFS_BASE_LO) begin
        base_lo <= wdata;
      end else if (ofs == vsd_pkg::OFS_CTRL) begin
        ctrl <= wdata;
      end
    end
  end

  // ==========================================================================
  // Settings that steer the conversion side
  logic [11:0]         fsr_now;
  assign fsr_now = ctrl[vsd_pkg::BIT_SLIDE] ? vsd_pkg::FSR_SLIDE : vsd_pkg::FSR_FULL;

  always_ff @(posedge clk) begin
    if (rst) begin
      base_addr        <= vsd_pkg::RST_BASE_ADDR;
      full_scale_range <= vsd_pkg::FSR_FULL;
      zs_step          <= vsd_pkg::ZS_STEP_COARSE;
      zs_span          <= vsd_pkg::FSR_FULL;
      irq_level        <= vsd_pkg::RST_IRQ_LVL;
    end else if (ce) begin
      base_addr        <= active_base;
      full_scale_range <= fsr_now;
      if (ctrl[vsd_pkg::BIT_ZS_FINE]) begin
        zs_step <= vsd_pkg::ZS_STEP_FINE;
        zs_span <= fsr_now >> vsd_pkg::ZS_FINE_SHIFT;
      end else begin
        zs_step <= vsd_pkg::ZS_STEP_COARSE;
        zs_span <= fsr_now;
      end
      irq_level <= ctrl[vsd_pkg::POS_IRQ_LVL +: 3] & vsd_pkg::IRQ_LEVEL_MAX;
    end
  end

  // ==========================================================================
  // Read data
  logic [15:0]         next_rdata;

  always_comb begin
    next_rdata = 16'h0000;
    if (next_space == vsd_pkg::SP_CSR) begin
      next_rdata = 16'h0000;
    end else if ((ofs == vsd_pkg::OFS_BITSET1) || (ofs == vsd_pkg::OFS_BITCLR1)) begin
      next_rdata = bitset1;
    end else if (ofs == vsd_pkg::OFS_BASE_HI) begin
      next_rdata = {8'h00, base_hi[7:0]};
    end else if (ofs == vsd_pkg::OFS_BASE_LO) begin
      next_rdata = {8'h00, base_lo[7:0]};
    end else if (ofs == vsd_pkg::OFS_CTRL) begin
      next_rdata = ctrl;
    end else if (ofs == vsd_pkg::OFS_STATUS) begin
      next_rdata = {11'h000, bitset1[vsd_pkg::BIT_BASE_SRC], space};
    end
  end

  // ==========================================================================
  // Cycle answer, one cycle after the address phase
  always_ff @(posedge clk) begin
    if (rst) begin
      space      <= vsd_pkg::SP_NONE;
      xfer       <= vsd_pkg::XF_SINGLE;
      board_sel  <= 1'b0;
      bus_ack    <= 1'b0;
      bus_err    <= 1'b0;
      buf_rd     <= 1'b0;
      reg_offset <= 16'h0000;
      rdata      <= 16'h0000;
    end else if (ce) begin
      board_sel <= req && next_hit;
      bus_ack   <= req && next_hit && (reg_ok || csr_ok);
      buf_rd    <= req && next_hit && (next_space != vsd_pkg::SP_CSR)
                && is_buf && buf_ok;
      bus_err   <= req && next_hit && !(reg_ok || csr_ok)
                && !((next_space != vsd_pkg::SP_CSR) && is_buf && buf_ok);
      if (req && next_hit) begin
        space      <= next_space;
        xfer       <= next_xfer;
        reg_offset <= ofs;
        rdata      <= wr ? 16'h0000 : next_rdata;
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_a24_sup;
    (ce && req && (am inside {6'h3F, 6'h3D, 6'h3C}) && (addr[23:16] == active_base[7:0]))
      |=> board_sel && (space == vsd_pkg::SP_A24);
  endproperty
  a_a24_sup: assert property (p_a24_sup) else $error("A24 supervisory not taken");

  property p_a24_usr;
    (ce && req && (am inside {6'h3B, 6'h39, 6'h38}) && (addr[23:16] == active_base[7:0]))
      |=> board_sel && (space == vsd_pkg::SP_A24);
  endproperty
  a_a24_usr: assert property (p_a24_usr) else $error("A24 user not taken");

  property p_a32_sup;
    (ce && req && (am inside {6'h0F, 6'h0D, 6'h0C}) && (addr[31:16] == active_base))
      |=> board_sel && (space == vsd_pkg::SP_A32);
  endproperty
  a_a32_sup: assert property (p_a32_sup) else $error("A32 supervisory not taken");

  property p_a32_usr;
    (ce && req && (am inside {6'h0B, 6'h09, 6'h08}) && (addr[31:16] == active_base))
      |=> board_sel && (space == vsd_pkg::SP_A32);
  endproperty
  a_a32_usr: assert property (p_a32_usr) else $error("A32 user not taken");

  property p_csr;
    (ce && req && (am == 6'h2F) && (addr[23:19] == geo_slot))
      |=> board_sel && (space == vsd_pkg::SP_CSR);
  endproperty
  a_csr: assert property (p_csr) else $error("CR/CSR cycle not taken");

  property p_offset;
    (ce && req && next_hit) |=> (reg_offset == $past(addr[15:0]));
  endproperty
  a_offset: assert property (p_offset) else $error("Offset not low address bits");

  property p_switch_base;
    (ce && req && !bitset1[vsd_pkg::BIT_BASE_SRC] && (am == 6'h09) && (addr[31:16] == rot_sw))
      |=> board_sel;
  endproperty
  a_switch_base: assert property (p_switch_base) else $error("Switch base not used");

  property p_reg_base;
    (ce && req && bitset1[vsd_pkg::BIT_BASE_SRC] && (am == 6'h09)
      && (addr[31:16] == {base_hi[7:0], base_lo[7:0]})) |=> board_sel;
  endproperty
  a_reg_base: assert property (p_reg_base) else $error("Register base not used");

  property p_reg_width;
    (ce && req && next_hit && (next_xfer != vsd_pkg::XF_SINGLE) && is_reg)
      |=> !bus_ack && bus_err;
  endproperty
  a_reg_width: assert property (p_reg_width) else $error("Block cycle hit register");

  property p_buf_mblt;
    (ce && req && next_hit && (next_space != vsd_pkg::SP_CSR) && is_buf && !wr
      && (next_xfer == vsd_pkg::XF_MBLT) && (dwidth == vsd_pkg::DW_D64)) |=> buf_rd;
  endproperty
  a_buf_mblt: assert property (p_buf_mblt) else $error("MBLT buffer read lost");

  property p_silent;
    (ce && req && (next_space == vsd_pkg::SP_NONE)) |=> !board_sel && !bus_ack && !bus_err;
  endproperty
  a_silent: assert property (p_silent) else $error("Answered unknown modifier");

  property p_slide;
    (ce && ctrl[vsd_pkg::BIT_SLIDE]) |=> (full_scale_range == 12'd3840);
  endproperty
  a_slide: assert property (p_slide) else $error("Sliding range not 3840");

  property p_zs_fine;
    (ce && ctrl[vsd_pkg::BIT_ZS_FINE] && !ctrl[vsd_pkg::BIT_SLIDE])
      |=> (zs_step == 5'd2) && (zs_span == 12'd511);
  endproperty
  a_zs_fine: assert property (p_zs_fine) else $error("Fine threshold wrong");

  c_reg_write: cover property (reg_wr ##1 bus_ack);
  c_buf_blt:   cover property (buf_rd && (xfer == vsd_pkg::XF_BLT));
  c_csr_read:  cover property (bus_ack && (space == vsd_pkg::SP_CSR));
  c_base_swap: cover property ($rose(base_from_regs) ##[1:20] board_sel);

endmodule : vsd_addr_decode

// file: sim/vsd_master.sv
// Bus master model issuing address phases to the decoder
module vsd_master (
  input  wire logic        clk,    // Bus clock
  output logic             req,    // Address phase strobe
  output logic [5:0]       am,     // Address modifier
  output logic [31:0]      addr,   // Address word
  output logic             wr,     // Write when high
  output logic [1:0]       dwidth, // Data width code
  output logic [15:0]      wdata   // Write data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {req, am, addr, wr, dwidth, wdata} = '0;
  end
  // One strobe cycle; released lines are scrambled so stale values never match
  task automatic access(input logic [5:0] a, input logic [31:0] ad, input logic w,
                        input logic [1:0] dw, input logic [15:0] d);
    @(negedge clk);
    {req, am, addr, wr, dwidth, wdata} <= {1'b1, a, ad, w, dw, d};
    @(negedge clk);
    {req, am, addr, wr, dwidth, wdata} <= {1'b0, ~a, ~ad, ~w, ~dw, ~d};
  endtask : access
endmodule : vsd_master

// file: sim/tb_vsd_addr_decode.sv
// Self-checking bench for the bus slave address decoder
module tb_vsd_addr_decode;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Signals and reference state
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1;
  logic [15:0] rot_sw = 16'h12EE;
  logic [4:0] geo_slot = 5'h05;
  logic req, wr, board_sel, bus_ack, bus_err, buf_rd, base_from_regs;
  logic [5:0] am;
  logic [31:0] addr;
  logic [1:0] dwidth;
  logic [15:0] wdata, reg_offset, rdata, base_addr, m_set, m_ctrl;
  logic [11:0] full_scale_range, zs_span;
  logic [4:0] zs_step;
  logic [2:0] irq_level;
  logic [7:0] m_hi, m_lo;
  vsd_pkg::vsd_space_e space;
  vsd_pkg::vsd_xfer_e xfer;
  vsd_pkg::vsd_space_e m_sp;
  int mismatches = 0, cmp_count = 0, seed = 32'h8d5f_2c7c;
  logic [31:0] r;
  localparam logic [5:0] AMS [13] = '{vsd_pkg::AM_A24_SUP_BLT, vsd_pkg::AM_A24_SUP_DATA,
    vsd_pkg::AM_A24_SUP_MBLT, vsd_pkg::AM_A24_USR_BLT, vsd_pkg::AM_A24_USR_DATA,
    vsd_pkg::AM_A24_USR_MBLT, vsd_pkg::AM_CR_CSR, vsd_pkg::AM_A32_SUP_BLT,
    vsd_pkg::AM_A32_SUP_DATA, vsd_pkg::AM_A32_SUP_MBLT, vsd_pkg::AM_A32_USR_BLT,
    vsd_pkg::AM_A32_USR_DATA, vsd_pkg::AM_A32_USR_MBLT};
  localparam logic [15:0] OFSS [8] = '{16'h0000, 16'h07FC, 16'h0800, 16'h1030,
    16'h1032, 16'h1036, 16'h1038, 16'h103A};
  always #20 clk = ~clk;
  vsd_master master (.clk(clk), .req(req), .am(am), .addr(addr), .wr(wr),
    .dwidth(dwidth), .wdata(wdata));
  vsd_addr_decode dut (.clk(clk), .rst(rst), .ce(ce), .req(req), .am(am), .addr(addr),
    .wr(wr), .dwidth(dwidth), .wdata(wdata), .rot_sw(rot_sw), .geo_slot(geo_slot),
    .space(space), .xfer(xfer), .board_sel(board_sel), .bus_ack(bus_ack),
    .bus_err(bus_err), .buf_rd(buf_rd), .reg_offset(reg_offset), .rdata(rdata),
    .base_from_regs(base_from_regs), .base_addr(base_addr),
    .full_scale_range(full_scale_range), .zs_step(zs_step), .zs_span(zs_span),
    .irq_level(irq_level));
  // ==========================================================================
  // Checking tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (e !== g) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  function automatic logic [15:0] cur_base();
    return m_set[4] ? {m_hi, m_lo} : rot_sw;
  endfunction : cur_base
  // Address that hits this board for modifier index k
  function automatic logic [31:0] at(input int k, input logic [15:0] o);
    logic [15:0] b;
    b = cur_base();
    return k == 6 ? {8'h00, geo_slot, 3'h0, o} : k < 6 ? {8'h5A, b[7:0], o} : {b, o};
  endfunction : at
  task automatic chk_set();
    logic [11:0] f;
    f = m_ctrl[0] ? 12'h0F00 : 12'h0FFF;
    chk("base_from_regs", m_set[4], base_from_regs);
    chk("base_addr", cur_base(), base_addr);
    chk("full_scale_range", f, full_scale_range);
    chk("zs_step", m_ctrl[1] ? 5'h02 : 5'h10, zs_step);
    chk("zs_span", m_ctrl[1] ? f >> 3 : f, zs_span);
    chk("irq_level", m_ctrl[4:2], irq_level);
  endtask : chk_set
  task automatic do_reset(input int n);
    rst = 1'b1;
    repeat (n) @(negedge clk);
    rst = 1'b0;
    {m_set, m_hi, m_lo, m_ctrl} = '0;
    m_sp = vsd_pkg::SP_NONE;
    @(negedge clk);
    chk("space", vsd_pkg::SP_NONE, space);
    chk_set();
  endtask : do_reset
  // One access through the master, compared with the reference decode
  task automatic step(input logic [5:0] a, input logic [31:0] ad, input logic w,
                      input logic [1:0] dw, input logic [15:0] d);
    int k;
    int j;
    vsd_pkg::vsd_space_e es;
    vsd_pkg::vsd_xfer_e ex;
    logic [15:0] b, o, rd;
    logic hit, ok, isbuf;
    k = -1;
    for (int i = 0; i < 13; i++) if (a == AMS[i]) k = i;
    j = (k % 7) % 3;
    es = k < 0 ? vsd_pkg::SP_NONE : k < 6 ? vsd_pkg::SP_A24 : k == 6 ? vsd_pkg::SP_CSR :
         vsd_pkg::SP_A32;
    ex = (k == 6 || j == 1) ? vsd_pkg::XF_SINGLE : j == 0 ? vsd_pkg::XF_BLT : vsd_pkg::XF_MBLT;
    b = cur_base();
    o = ad[15:0];
    hit = (es == vsd_pkg::SP_A24 && ad[23:16] == b[7:0]) || (es == vsd_pkg::SP_A32 &&
          ad[31:16] == b) || (es == vsd_pkg::SP_CSR && ad[23:19] == geo_slot);
    isbuf = es != vsd_pkg::SP_CSR && o < 16'h0800;
    if (isbuf) ok = !w && dw == (ex == vsd_pkg::XF_MBLT ? vsd_pkg::DW_D64 : vsd_pkg::DW_D32);
    else ok = ex == vsd_pkg::XF_SINGLE && dw inside {vsd_pkg::DW_D16, vsd_pkg::DW_D32} &&
              (es == vsd_pkg::SP_CSR || o inside {[16'h1030 : 16'h103A]} && !o[0]);
    master.access(a, ad, w, dw, d);
    chk("board_sel", hit, board_sel);
    chk("bus_ack", hit && ok && !isbuf, bus_ack);
    chk("buf_rd", hit && ok && isbuf, buf_rd);
    chk("bus_err", hit && !ok, bus_err);
    if (hit) begin
      chk("space", es, space);
      chk("xfer", ex, xfer);
      chk("reg_offset", o, reg_offset);
      rd = 16'h0000;
      if (!w && es != vsd_pkg::SP_CSR) begin
        case (o)
          16'h1030, 16'h1032: rd = m_set;
          16'h1034: rd = {8'h00, m_hi};
          16'h1036: rd = {8'h00, m_lo};
          16'h1038: rd = m_ctrl;
          16'h103A: rd = {11'h000, m_set[4], m_sp};
          default: ;
        endcase
      end
      chk("rdata", rd, rdata);
      m_sp = es;
      if (ok && w && es != vsd_pkg::SP_CSR) begin
        case (o)
          16'h1030: m_set = m_set | d;
          16'h1032: m_set = m_set & ~d;
          16'h1034: m_hi = d[7:0];
          16'h1036: m_lo = d[7:0];
          16'h1038: m_ctrl = d;
          default: ;
        endcase
      end
    end
    @(negedge clk);
    chk_set();
  endtask : step
  // ==========================================================================
  // Scenarios
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    conclude();
  end
  initial begin
    do_reset(5);
    for (int k = 0; k < 13; k++) step(AMS[k], at(k, 16'h1036), 1'b0, 2'h1, 16'h0000);
    step(AMS[11], at(11, 16'h1034), 1'b1, 2'h1, 16'h00AB);
    step(AMS[4], at(4, 16'h1036), 1'b1, 2'h2, 16'h00CD);
    step(AMS[11], at(11, 16'h1030), 1'b1, 2'h1, 16'h0010);
    step(AMS[11], {rot_sw, 16'h103A}, 1'b0, 2'h1, 16'h0000);
    step(AMS[11], at(11, 16'h1036), 1'b0, 2'h1, 16'h0000);
    step(AMS[4], at(4, 16'h103A), 1'b0, 2'h2, 16'h0000);
    step(AMS[8], at(8, 16'h1032), 1'b1, 2'h1, 16'h0010);
    for (int i = 0; i < 32; i++) step(AMS[8], at(8, 16'h1038), 1'b1, 2'h1, 16'(i));
    // Clock enable low: the strobe is not taken and the control write must not land
    ce = 1'b0;
    master.access(AMS[8], at(8, 16'h1038), 1'b1, 2'h1, 16'h0011);
    chk("board_sel", 1'b0, board_sel);
    @(negedge clk);
    chk_set();
    ce = 1'b1;
    for (int k = 0; k < 13; k++)
      for (int j = 0; j < 16; j++)
        step(AMS[k], at(k, j[3] ? 16'h103A : 16'h0000), j[2], j[1:0], 16'h0000);
    do_reset(2);
    repeat (400) begin
      r = $random(seed);
      if (r[9:6] == 4'h0) rot_sw = 16'($random(seed));
      step(r[4] ? AMS[r[3:0] % 13] : r[10:5], r[15] ? at(r[3:0] % 13, OFSS[r[14:12]]) :
           {r[31:16], OFSS[r[14:12]]}, r[11], r[18:17], r[31:16]);
    end
    conclude();
  end
endmodule : tb_vsd_addr_decode
